// ==== hdl/dual_supply_reset_delay.v ====
// Dual supply supervisor: select decode, filtering and reset delay timer
`include "supply_monitor_map.vh"

// Functional notes
// [RL1] Select pins are tied low, tied high or floating; three states each.
// [RL2] A tri-stated buffer on a select pin reads as the floating state.
// [RL3] Pairs high/high, open/low, high/open, open/high, open/open give 3.3V-class settings.
// [RL4] Pairs low/low, low/open, low/high, high/low give 2.5V-class settings.
// [RL5] Tolerance pin: high 5%, open 7.5%, low 10%, common to both channels.
// [RL6] Each comparator result is low-pass filtered before the reset logic.
// [RL7] Any channel low: active-low reset low, active-high reset high.
// [RL8] Both supplies good starts the delay timer from zero.
// [RL9] Timer done with supplies good releases both reset outputs.
// [RL10] A dip during counting clears the timer; restart at next recovery.
// [RL11] Assertion never waits for the timer, only for filtering.
// [RL12] Fixed variant delays 200 ms; adjustable variant uses a capacitor.
// [RL13] Adjustable delay scales at 110 nF per second.
// [RL14] No capacitor still gives about 200 us minimum delay.
// [RL15] Reset outputs are open-drain style; pull low only, wire-OR capable.
// [RL16] Selections latch once supply one reaches 2.17 V; faults act after.
// [RL17] Reset held asserted from 1 V supply, before thresholds valid.
// [RL18] Comparators synchronised; filter and delay counted in clock cycles.
module dual_supply_reset_delay #(
   parameter        ADJUSTABLE = 0,
   parameter [15:0] CAP_NF     = 16'h0016,
   parameter [31:0] DELAY_CYC  = `DELAY_FIXED_CYC,
   parameter [31:0] MIN_CYC    = `DELAY_MIN_CYC,
   parameter [15:0] FILTER_CYC = `FILTER_CYC
) (
   input  wire       clk_in,
   input  wire       rstn_in,
   input  wire       vcc_alive_in,
   input  wire       supply_one_programmed_in,
   input  wire       below_one_in,
   input  wire       below_two_in,
   input  wire       pair_select_a_hi_in,
   input  wire       pair_select_a_lo_in,
   input  wire       pair_select_b_hi_in,
   input  wire       pair_select_b_lo_in,
   input  wire       tolerance_select_hi_in,
   input  wire       tolerance_select_lo_in,
   output reg  [5:0] nominal_one_dv_out,
   output reg  [5:0] nominal_two_dv_out,
   output reg  [1:0] tolerance_out,
   output reg        select_valid_out,
   output wire       reset_n_out,
   output wire       reset_n_oe_out,
   output wire       reset_out,
   output wire       reset_oe_out
);
   // Delay count chosen from the variant
   localparam [31:0] CAP_CYC   = CAP_NF * `CYC_PER_NF;
   localparam [31:0] ADJ_CYC   = (CAP_CYC > MIN_CYC) ? CAP_CYC : MIN_CYC;   // [RL14]
   localparam [31:0] RELEASE_N = ADJUSTABLE ? ADJ_CYC : DELAY_CYC;         // [RL12] [RL13]

   // One-hot states
   localparam [2:0] ST_HOLD  = 3'h1;
   localparam [2:0] ST_COUNT = 3'h2;
   localparam [2:0] ST_RUN   = 3'h4;

   reg        rst_m, rst_n;
   reg  [7:0] sync_a, sync_b;
   reg  [2:0] state, next_state;
   reg [31:0] timer;
   wire       good_one, good_two, both_good;

   // Reset release through two flops
   always @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rst_m <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_n <= rst_m;
      end
   end

   // Pin synchronisers; sync_a stage is read only by sync_b
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 8'h00;
         sync_b <= 8'h00;
      end else begin
         sync_a <= {vcc_alive_in, supply_one_programmed_in, below_one_in, below_two_in,
                    pair_select_a_hi_in, pair_select_a_lo_in, pair_select_b_hi_in, pair_select_b_lo_in};
         sync_b <= sync_a;                                                  // [RL18]
      end
   end

   reg  [1:0] tol_sync_a, tol_sync_b;
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         tol_sync_a <= 2'h0;
         tol_sync_b <= 2'h0;
      end else begin
         tol_sync_a <= {tolerance_select_hi_in, tolerance_select_lo_in};
         tol_sync_b <= tol_sync_a;
      end
   end

   // Three-state decode: neither level seen means floating or tri-stated
   function [1:0] tri_decode;
      input hi;
      input lo;
      begin
         if (hi)
            tri_decode = `PIN_HIGH;
         else if (lo)
            tri_decode = `PIN_LOW;
         else
            tri_decode = `PIN_OPEN;                                          // [RL1] [RL2]
      end
   endfunction

   wire [1:0] code_a   = tri_decode(sync_b[3], sync_b[2]);
   wire [1:0] code_b   = tri_decode(sync_b[1], sync_b[0]);
   wire [1:0] code_tol = tri_decode(tol_sync_b[1], tol_sync_b[0]);

   // Latch the selection once supply one is high enough; held afterwards
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         nominal_one_dv_out <= 6'h00;
         nominal_two_dv_out <= 6'h00;
         tolerance_out      <= `TOL_10;
         select_valid_out   <= 1'b0;
      end else if (sync_b[6] && !select_valid_out) begin                 // [RL16]
         select_valid_out <= 1'b1;
         case ({code_a, code_b})
            {`PIN_HIGH, `PIN_HIGH}: begin                                   // [RL3]
               nominal_one_dv_out <= `DV_5P0;
               nominal_two_dv_out <= `DV_3P3;
            end
            {`PIN_OPEN, `PIN_LOW }: begin                                   // [RL3]
               nominal_one_dv_out <= `DV_3P3;
               nominal_two_dv_out <= `DV_2P5;
            end
            {`PIN_HIGH, `PIN_OPEN}: begin                                   // [RL3]
               nominal_one_dv_out <= `DV_3P3;
               nominal_two_dv_out <= `DV_1P8;
            end
            {`PIN_OPEN, `PIN_HIGH}: begin                                   // [RL3]
               nominal_one_dv_out <= `DV_3P3;
               nominal_two_dv_out <= `DV_1P5;
            end
            {`PIN_OPEN, `PIN_OPEN}: begin                                   // [RL3]
               nominal_one_dv_out <= `DV_3P3;
               nominal_two_dv_out <= `DV_1P2;
            end
            {`PIN_LOW,  `PIN_LOW }: begin                                   // [RL4]
               nominal_one_dv_out <= `DV_2P5;
               nominal_two_dv_out <= `DV_1P8;
            end
            {`PIN_LOW,  `PIN_OPEN}: begin                                   // [RL4]
               nominal_one_dv_out <= `DV_2P5;
               nominal_two_dv_out <= `DV_1P5;
            end
            {`PIN_LOW,  `PIN_HIGH}: begin                                   // [RL4]
               nominal_one_dv_out <= `DV_2P5;
               nominal_two_dv_out <= `DV_1P2;
            end
            // High/low is the only pairing left; the 2'h3 code cannot occur
            default: begin                                                  // [RL4]
               nominal_one_dv_out <= `DV_2P5;
               nominal_two_dv_out <= `DV_1P0;
            end
         endcase
         // Larger tolerance means a lower trip point
         case (code_tol)
            `PIN_HIGH: tolerance_out <= `TOL_5;                             // [RL5]
            `PIN_OPEN: tolerance_out <= `TOL_7P5;                           // [RL5]
            default:   tolerance_out <= `TOL_10;                            // [RL5]
         endcase
      end
   end

   // Comparator filters, one per channel; input is the "good" sense
   low_pass_filter #(.CNT_W(16), .FULL(FILTER_CYC)) filter_one (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n),
      .raw_in       (~sync_b[5]),                                          // [RL6]
      .filtered_out (good_one)
   );
   low_pass_filter #(.CNT_W(16), .FULL(FILTER_CYC)) filter_two (
      .clk_in       (clk_in),
      .rst_n_in     (rst_n),
      .raw_in       (~sync_b[4]),                                          // [RL6]
      .filtered_out (good_two)
   );

   // Faults count only once the selection is valid
   assign both_good = select_valid_out & good_one & good_two;

   // Sequencer next state
   always @* begin
      next_state = state;
      case (state)
         ST_HOLD:  if (both_good) next_state = ST_COUNT;                   // [RL8]
         ST_COUNT: if (!both_good) next_state = ST_HOLD;                   // [RL10]
                   else if (timer >= RELEASE_N - 32'h1) next_state = ST_RUN; // [RL9]
         ST_RUN:   if (!both_good) next_state = ST_HOLD;                   // [RL7] [RL11]
         default:  next_state = ST_HOLD;
      endcase
   end

   // State and timer; the timer only runs in the counting state
   always @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_HOLD;
         timer <= 32'h0;
      end else begin
         state <= next_state;
         if (state == ST_COUNT && both_good)
            timer <= timer + 32'h1;
         else
            timer <= 32'h0;                                                 // [RL10]
      end
   end

   // Open-drain outputs: drive low only, pull-up lives outside
   wire asserted = (state != ST_RUN);                                      // [RL17]
   assign reset_n_out    = 1'b0;                                           // [RL15]
   assign reset_n_oe_out = asserted & sync_b[7];                           // [RL7]
   assign reset_out      = 1'b0;
   assign reset_oe_out   = ~asserted & sync_b[7];                          // [RL9]
endmodule // dual_supply_reset_delay

// ==== hdl/low_pass_filter.v ====
// Integrating filter for one comparator result
module low_pass_filter #(
   parameter CNT_W = 16,
   parameter [CNT_W-1:0] FULL = 16'h03E8
) (
   input  wire             clk_in,
   input  wire             rst_n_in,
   input  wire             raw_in,
   output reg              filtered_out
);
   reg [CNT_W-1:0] level;

   // Counter integrates toward the raw level; output flips only at the rails
   always @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         level        <= {CNT_W{1'b0}};
         filtered_out <= 1'b1;
      end else begin
         if (raw_in && level != FULL)
            level <= level + 1'b1;
         else if (!raw_in && level != {CNT_W{1'b0}})
            level <= level - 1'b1;
         // Short glitches never reach a rail, so they never pass
         if (level == FULL)
            filtered_out <= 1'b1;
         else if (level == {CNT_W{1'b0}})
            filtered_out <= 1'b0;
      end
   end
endmodule // low_pass_filter

// ==== hdl/supply_monitor_map.vh ====
// Constants of the dual supply reset sequencer
`ifndef SUPPLY_MONITOR_MAP_VH
`define SUPPLY_MONITOR_MAP_VH

// Three-state pin codes after decode
`define PIN_LOW              2'h0
`define PIN_OPEN             2'h1
`define PIN_HIGH             2'h2

// Tolerance codes
`define TOL_5                2'h0
`define TOL_7P5              2'h1
`define TOL_10               2'h2

// Nominal voltages in tenths of a volt (decivolts)
`define DV_5P0               6'h32
`define DV_3P3               6'h21
`define DV_2P5               6'h19
`define DV_1P8               6'h12
`define DV_1P5               6'h0F
`define DV_1P2               6'h0C
`define DV_1P0               6'h0A

// Timing figures as printed
`define CLK_PERIOD_NS        10
`define DELAY_FIXED_MS       200
`define DELAY_MIN_US         200
`define CAP_NF_PER_S         110
`define FILTER_US            10

// Cycle counts derived from the figures
`define DELAY_FIXED_CYC      ((`DELAY_FIXED_MS * 1000000) / `CLK_PERIOD_NS)
`define DELAY_MIN_CYC        ((`DELAY_MIN_US * 1000) / `CLK_PERIOD_NS)
`define FILTER_CYC           ((`FILTER_US * 1000) / `CLK_PERIOD_NS)
// Cycles per nF of timing capacitor: 1 s / 110 nF
`define CYC_PER_NF           ((1000000000 / `CLK_PERIOD_NS) / `CAP_NF_PER_S)

`endif

// ==== test/dual_supply_reset_delay_monitor.sv ====
// Port checker of the dual supply reset sequencer
module dual_supply_reset_delay_monitor #(
   parameter [31:0] DELAY_CYC  = 50,
   parameter [15:0] FILTER_CYC = 4
) (
   input wire       clk_in,
   input wire       rstn_in,
   input wire       vcc_alive_in,
   input wire       supply_one_programmed_in,
   input wire       below_one_in,
   input wire       below_two_in,
   input wire [5:0] nominal_one_dv_out,
   input wire [5:0] nominal_two_dv_out,
   input wire [1:0] tolerance_out,
   input wire       select_valid_out,
   input wire       reset_n_oe_out,
   input wire       reset_oe_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);
   // Slack covers sync, filter and state latency
   localparam int LIM = DELAY_CYC + FILTER_CYC + 20;
   logic [31:0] good_cnt;
   wire ok = vcc_alive_in && select_valid_out && !below_one_in && !below_two_in;
   // Consecutive good cycles, saturating
   always @(posedge clk_in or negedge rstn_in)
      if (!rstn_in) good_cnt <= 32'h0;
      else good_cnt <= !ok ? 32'h0 : (good_cnt == LIM) ? good_cnt : good_cnt + 32'h1;
   drive_excl_a: assert property (!(reset_n_oe_out && reset_oe_out)) else $error("both pulled");
   dead_rail_a: assert property (!vcc_alive_in [*3] |-> !reset_n_oe_out && !reset_oe_out)
      else $error("drive while unpowered");
   early_hold_a: assert property (vcc_alive_in [*8] ##0 !select_valid_out |-> reset_n_oe_out)
      else $error("released before latch");
   // Two sync stages, filter drain, filter output and state flop: pull-down shows one cycle after the run
   fault_one_a: assert property ((below_one_in && vcc_alive_in) [*8] |=> reset_n_oe_out)
      else $error("channel one fault ignored");
   fault_two_a: assert property ((below_two_in && vcc_alive_in) [*8] |=> reset_n_oe_out)
      else $error("channel two fault ignored");
   rel_early_a: assert property ($rose(reset_oe_out) |-> good_cnt >= DELAY_CYC)
      else $error("release too early");
   rel_late_a: assert property (good_cnt == LIM |-> reset_oe_out && !reset_n_oe_out)
      else $error("release too late");
   sel_hold_a: assert property (select_valid_out |=> select_valid_out && $stable(tolerance_out)
      && $stable(nominal_one_dv_out) && $stable(nominal_two_dv_out)) else $error("selection moved");
   sel_time_a: assert property ($rose(supply_one_programmed_in) && !select_valid_out
      |-> ##[2:3] select_valid_out) else $error("selection not latched");
endmodule // dual_supply_reset_delay_monitor

// Adjustable instances are checked against the minimum delay, which rules only without a timing capacitor
bind dual_supply_reset_delay dual_supply_reset_delay_monitor
   #(.DELAY_CYC(ADJUSTABLE ? MIN_CYC : DELAY_CYC), .FILTER_CYC(FILTER_CYC))
   i_mon (.clk_in(clk_in), .rstn_in(rstn_in), .vcc_alive_in(vcc_alive_in), .below_one_in(below_one_in),
   .supply_one_programmed_in(supply_one_programmed_in), .below_two_in(below_two_in),
   .nominal_one_dv_out(nominal_one_dv_out), .nominal_two_dv_out(nominal_two_dv_out), .tolerance_out(tolerance_out),
   .select_valid_out(select_valid_out), .reset_n_oe_out(reset_n_oe_out), .reset_oe_out(reset_oe_out));

// ==== test/dual_supply_reset_delay_tb.sv ====
// Self-checking bench of the dual supply reset sequencer
`include "supply_monitor_map.vh"
module dual_supply_reset_delay_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DLY = 50;
   localparam int FLT = 4;
   logic        clk_in = 1'b0, rstn_in = 1'b0, vcc = 1'b0, prog = 1'b0;
   logic        below_one = 1'b1, below_two = 1'b1;
   logic [1:0]  sa = 2'h0, sb = 2'h0, st = 2'h0, tolerance_select;
   logic [5:0]  pins, nom_one, nom_two;
   logic        valid, n_oe, oe, reset_n_line, reset_line;
   logic        n_oe_adj, oe_adj, n_drv, drv;
   logic [31:0] seed = 32'h0000B28F;
   int          miscompares = 0, compares = 0, cyc;
   always #5 clk_in = ~clk_in;
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Expected nominal pair, codes low 0, open 1, high 2
   function automatic logic [11:0] exp_pair(input logic [3:0] ab);
      case (ab)
         4'hA: return {`DV_5P0, `DV_3P3};
         4'h4: return {`DV_3P3, `DV_2P5};
         4'h9: return {`DV_3P3, `DV_1P8};
         4'h6: return {`DV_3P3, `DV_1P5};
         4'h5: return {`DV_3P3, `DV_1P2};
         4'h0: return {`DV_2P5, `DV_1P8};
         4'h1: return {`DV_2P5, `DV_1P5};
         4'h2: return {`DV_2P5, `DV_1P2};
         default: return {`DV_2P5, `DV_1P0};
      endcase
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Compare on the falling edge, where outputs have settled
   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      @(negedge clk_in);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wrap_up();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Bounded wait for a pull-down pattern, cycles waited in cyc
   task automatic wait_state(input logic [1:0] s, input int lim);
      cyc = 0;
      do begin
         @(negedge clk_in);
         cyc++;
      end while ({n_oe, oe} !== s && cyc < lim);
      check("pull-down state", s, {n_oe, oe});
      if ({n_oe, oe} !== s) wrap_up();
   endtask
   // Reset, power up and latch one strap setting
   task automatic latch(input logic [1:0] a, input logic [1:0] b, input logic [1:0] t);
      tick(1);
      {rstn_in, prog, vcc, below_one, below_two} <= 5'h03;
      {sa, sb, st} <= {a, b, t};
      tick(2);
      rstn_in <= 1'b1;
      check("unpowered", 2'h0, {n_oe, oe});
      tick(1);
      vcc <= 1'b1;
      tick(8);
      check("held lines", 2'h1, {reset_n_line, reset_line});
      check("not yet valid", 1'b0, valid);
      tick(1);
      prog <= 1'b1;
      tick(5);
      check("pair", exp_pair({a, b}), {nom_one, nom_two});
      check("tolerance", t == 2'h2 ? `TOL_5 : t == 2'h1 ? `TOL_7P5 : `TOL_10, tolerance_select);
      check("select valid", 1'b1, valid);
      tick(1);
      {sa, sb, st} <= {2'(rnd() % 3), 2'(rnd() % 3), 2'(rnd() % 3)};
      tick(4);
      check("latched pair", exp_pair({a, b}), {nom_one, nom_two});
   endtask
   initial begin
      for (int i = 0; i < 9; i++) latch(2'(i / 3), 2'(i % 3), 2'((i + 1) % 3));
      tick(1);
      {below_one, below_two} <= 2'h0;
      wait_state(2'h1, DLY + FLT + 20);
      check("release delay", 1'b1, cyc >= DLY);
      check("released lines", 2'h2, {reset_n_line, reset_line});
      check("minimum delay", 2'h1, {n_oe_adj, oe_adj});
      tick(1);
      below_two <= 1'b1;
      tick(1 + rnd() % (FLT - 2));
      below_two <= 1'b0;
      tick(12);
      check("short glitch", 2'h1, {n_oe, oe});
      tick(1);
      below_one <= 1'b1;
      wait_state(2'h2, FLT + 6);
      tick(1);
      below_one <= 1'b0;
      tick(FLT + 23 + rnd() % 20);
      check("still counting", 2'h2, {n_oe, oe});
      tick(1);
      below_two <= 1'b1;
      tick(FLT + 4);
      below_two <= 1'b0;
      wait_state(2'h1, DLY + FLT + 20);
      check("fresh count", 1'b1, cyc >= DLY);
      wrap_up();
   end
   supply_side_model i_supply_side_model (.strap_a_in(sa), .strap_b_in(sb), .strap_tol_in(st), .pins_out(pins),
      .reset_n_oe_in(n_oe), .reset_oe_in(oe), .reset_n_drv_in(n_drv), .reset_drv_in(drv),
      .reset_n_line_out(reset_n_line), .reset_line_out(reset_line));
   dual_supply_reset_delay #(.DELAY_CYC(DLY), .MIN_CYC(20), .FILTER_CYC(FLT)) i_dual_supply_reset_delay (
      .clk_in(clk_in), .rstn_in(rstn_in), .vcc_alive_in(vcc), .supply_one_programmed_in(prog),
      .below_one_in(below_one), .below_two_in(below_two), .pair_select_a_hi_in(pins[5]),
      .pair_select_a_lo_in(pins[4]), .pair_select_b_hi_in(pins[3]), .pair_select_b_lo_in(pins[2]),
      .tolerance_select_hi_in(pins[1]), .tolerance_select_lo_in(pins[0]), .nominal_one_dv_out(nom_one),
      .nominal_two_dv_out(nom_two), .tolerance_out(tolerance_select), .select_valid_out(valid), .reset_n_out(n_drv),
      .reset_n_oe_out(n_oe), .reset_out(drv), .reset_oe_out(oe));
   // Adjustable variant with no timing capacitor; only the minimum delay holds reset
   dual_supply_reset_delay #(.ADJUSTABLE(1), .CAP_NF(16'h0000), .MIN_CYC(20), .FILTER_CYC(FLT))
      i_dual_supply_reset_delay_adj (
      .clk_in(clk_in), .rstn_in(rstn_in), .vcc_alive_in(vcc), .supply_one_programmed_in(prog),
      .below_one_in(below_one), .below_two_in(below_two), .pair_select_a_hi_in(pins[5]),
      .pair_select_a_lo_in(pins[4]), .pair_select_b_hi_in(pins[3]), .pair_select_b_lo_in(pins[2]),
      .tolerance_select_hi_in(pins[1]), .tolerance_select_lo_in(pins[0]), .nominal_one_dv_out(),
      .nominal_two_dv_out(), .tolerance_out(), .select_valid_out(), .reset_n_out(),
      .reset_n_oe_out(n_oe_adj), .reset_out(), .reset_oe_out(oe_adj));
endmodule // dual_supply_reset_delay_tb

// ==== test/supply_side_model.sv ====
// Straps and reset lines around the sequencer
module supply_side_model (
   input  wire [1:0] strap_a_in,
   input  wire [1:0] strap_b_in,
   input  wire [1:0] strap_tol_in,
   input  wire       reset_n_oe_in,
   input  wire       reset_oe_in,
   input  wire       reset_n_drv_in,
   input  wire       reset_drv_in,
   output wire [5:0] pins_out,
   output wire       reset_n_line_out,
   output wire       reset_line_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Open strap or idle buffer reads neither high nor low
   assign pins_out = {strap_a_in == 2'h2, strap_a_in == 2'h0, strap_b_in == 2'h2,
                      strap_b_in == 2'h0, strap_tol_in == 2'h2, strap_tol_in == 2'h0};
   // Weak pull-up wins only while nothing pulls low
   assign reset_n_line_out = reset_n_oe_in ? reset_n_drv_in : 1'b1;
   assign reset_line_out   = reset_oe_in ? reset_drv_in : 1'b1;
endmodule // supply_side_model
